// ### tlpi_ctrl.sv
// Contract
// - High vector 0008h, low vector 0018h
// - High request preempts running low routine
// - Per source flag, enable, priority bits (priority bits only for sources 0, 1, 6, 7)
// - Priority bits ignored while levels disabled
// - Peripheral enable gates peripherals with main
// - Main enable clear blocks every source
// - Compatibility mode always vectors 0008h
// - High-level enable permits high sources
// - High-level enable clear blocks all
// - Low sources need both level enables
// - Taking interrupt clears its level enable
// - No low request during high routine
// - Push return address, load vector
// - Return instruction sets exited level enable
// - Event to vector three or four cycles
// - Latency independent of instruction length
// - Flags set regardless of enables
// - Priority bit1 threshold, bit0 conversion done
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module tlpi_ctrl
  import tlpi_pkg::*;
#(
  parameter logic [SRC_N-1:0] PERIPH_MASK = 8'hff
) (
  // Clock and reset
  input  wire  logic             pclk,
  input  wire  logic             presetn,
  // APB slave
  input  wire  logic             psel,
  input  wire  logic             penable,
  input  wire  logic             pwrite,
  input  wire  logic [7:0]       paddr,
  input  wire  logic [31:0]      pwdata,
  input  wire  logic [3:0]       pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Event sources
  input  wire  logic [SRC_N-1:0] src_event,
  // Core sequencer
  input  wire  logic [VEC_W-1:0] core_ret_pc,
  input  wire  logic             core_return_from_interrupt_instr,
  output logic                   irq_pending,
  output logic                   vec_load,
  output logic [VEC_W-1:0]       vec_addr,
  output logic                   stack_push,
  output logic [VEC_W-1:0]       stack_push_data
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    tlpi_state_t      st;
    logic             high_level_global_enable;
    logic             low_level_global_enable;
    logic             priority_levels_enable;
    logic [SRC_N-1:0] flag;
    logic [SRC_N-1:0] en;
    logic [SRC_N-1:0] prio;
    logic             in_high;
    logic             in_low;
    logic             vec_load;
    logic [VEC_W-1:0] vec_addr;
    logic [VEC_W-1:0] push_data;
    logic [31:0]      prdata;
  } tlpi_regs_t;

  tlpi_regs_t q_r;
  tlpi_regs_t q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification

  logic [SRC_N-1:0] armed;
  logic [SRC_N-1:0] compat_req;
  logic [SRC_N-1:0] high_req;
  logic [SRC_N-1:0] low_req;
  logic             any_high;
  logic             any_low;
  logic             any_req;

  assign armed = q_r.flag & q_r.en;

  // Priority bits take no part here
  assign compat_req = armed & {SRC_N{q_r.high_level_global_enable}}
                    & (~PERIPH_MASK | {SRC_N{q_r.low_level_global_enable}});

  assign high_req = armed & q_r.prio & {SRC_N{q_r.high_level_global_enable}};
  assign low_req  = armed & ~q_r.prio & {SRC_N{q_r.high_level_global_enable & q_r.low_level_global_enable}}
                  & {SRC_N{~q_r.in_high}};

  assign any_high = q_r.priority_levels_enable ? (|high_req) : (|compat_req);
  assign any_low  = q_r.priority_levels_enable & (|low_req);
  assign any_req  = any_high | any_low;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic        setup_ph;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] rd_val;

  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & pstrb[0] & addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_val  = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: begin
        rd_val[CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT] = q_r.high_level_global_enable;
        rd_val[CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT] = q_r.low_level_global_enable;
        rd_val[CTRL_PRIORITY_LEVELS_ENABLE_BIT] = q_r.priority_levels_enable;
      end
      ADDR_FLAG:   rd_val[SRC_N-1:0] = q_r.flag;
      ADDR_ENABLE: rd_val[SRC_N-1:0] = q_r.en;
      ADDR_PRIO:   rd_val[SRC_N-1:0] = q_r.prio & PRIO_IMPL;
      ADDR_STATUS: begin
        rd_val[STAT_INHI_BIT] = q_r.in_high;
        rd_val[STAT_INLO_BIT] = q_r.in_low;
        rd_val[STAT_BUSY_BIT] = (q_r.st != S_IDLE);
      end
      default: addr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    q_nxt          = q_r;
    q_nxt.vec_load = 1'b0;
    if (setup_ph) begin
      q_nxt.prdata = rd_val;
    end
    // Software writes first so hardware updates below take precedence
    if (wr_en) begin
      unique case (paddr)
        ADDR_CTRL: begin
          q_nxt.high_level_global_enable = pwdata[CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT];
          q_nxt.low_level_global_enable = pwdata[CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT];
          q_nxt.priority_levels_enable = pwdata[CTRL_PRIORITY_LEVELS_ENABLE_BIT];
        end
        ADDR_FLAG:   q_nxt.flag = pwdata[SRC_N-1:0];
        ADDR_ENABLE: q_nxt.en   = pwdata[SRC_N-1:0];
        ADDR_PRIO:   q_nxt.prio = pwdata[SRC_N-1:0] & PRIO_IMPL;
        default: begin
        end
      endcase
    end
    // An event in the clearing cycle still sets its flag
    q_nxt.flag = q_nxt.flag | src_event;

    // Return: re-enable the level being left
    if (core_return_from_interrupt_instr) begin
      if (!q_r.priority_levels_enable) begin
        q_nxt.high_level_global_enable    = 1'b1;
        q_nxt.in_high = 1'b0;
      end else if (q_r.in_high) begin
        q_nxt.high_level_global_enable    = 1'b1;
        q_nxt.in_high = 1'b0;
      end else if (q_r.in_low) begin
        q_nxt.low_level_global_enable   = 1'b1;
        q_nxt.in_low = 1'b0;
      end
    end

    // Fixed two-stage pipe: timing never looks at the running instruction
    unique case (q_r.st)
      S_IDLE: begin
        if (any_req) begin
          q_nxt.st = S_SYNC;
        end
      end
      S_SYNC: begin
        if (any_high) begin
          // Also the preemption path out of a low routine
          q_nxt.st        = S_VECT;
          q_nxt.vec_load  = 1'b1;
          q_nxt.vec_addr  = VEC_HIGH;
          q_nxt.push_data = core_ret_pc;
          q_nxt.high_level_global_enable      = 1'b0;
          q_nxt.in_high   = 1'b1;
        end else if (any_low) begin
          q_nxt.st        = S_VECT;
          q_nxt.vec_load  = 1'b1;
          q_nxt.vec_addr  = VEC_LOW;
          q_nxt.push_data = core_ret_pc;
          q_nxt.low_level_global_enable      = 1'b0;
          q_nxt.in_low    = 1'b1;
        end else begin
          // Request withdrawn by software before it was taken
          q_nxt.st = S_IDLE;
        end
      end
      S_VECT: q_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r           <= '0;
      q_r.st        <= S_IDLE;
      q_r.prio      <= PRIO_RESET;
      q_r.vec_addr  <= VEC_HIGH;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states: read data is captured in the setup phase
  assign pready          = 1'b1;
  assign pslverr         = psel & penable & ~addr_ok;
  assign prdata          = q_r.prdata;
  assign irq_pending     = any_req;
  assign vec_load        = q_r.vec_load;
  assign vec_addr        = q_r.vec_addr;
  assign stack_push      = q_r.vec_load;
  assign stack_push_data = q_r.push_data;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_sets: assert property (
    (src_event != '0) |=> ((q_r.flag & $past(src_event)) == $past(src_event)))
    else $error("event flag not set");

  a_vec_map: assert property (
    vec_load |-> (q_r.in_high && vec_addr == VEC_HIGH)
               || (q_r.in_low && vec_addr == VEC_LOW))
    else $error("vector does not match level");

  a_compat_vec: assert property (
    (vec_load && !q_r.priority_levels_enable) |-> vec_addr == VEC_HIGH)
    else $error("compatibility vector wrong");

  a_take_clears: assert property (
    $rose(vec_load) && vec_addr == VEC_HIGH |-> !q_r.high_level_global_enable)
    else $error("global enable not cleared");

  a_latency_pipe: assert property (
    (q_r.st == S_IDLE && any_req) |=> q_r.st == S_SYNC
      ##1 (q_r.st == S_VECT || q_r.st == S_IDLE))
    else $error("response latency broken");

  a_no_low_high: assert property (
    (q_r.priority_levels_enable && q_r.in_high) |-> low_req == '0)
    else $error("low request during high routine");

  a_block_all: assert property (
    !q_r.high_level_global_enable |-> !irq_pending)
    else $error("request while globally blocked");

  a_return_from_interrupt_instr_high: assert property (
    (core_return_from_interrupt_instr && q_r.in_high && !wr_en) |=> q_r.high_level_global_enable && !q_r.in_high)
    else $error("return did not re-enable");

  a_push_vec: assert property (
    $rose(vec_load) |-> stack_push && stack_push_data == $past(core_ret_pc))
    else $error("return address not pushed");

  a_preempt: assert property (
    (q_r.priority_levels_enable && q_r.in_low && q_r.st == S_IDLE && any_high) |-> ##2 (vec_load
                                                                    || q_r.st == S_IDLE))
    else $error("high request did not preempt");

  // Gating per mode and level, then vectoring, return and sequencing checks
  a_pending_flag: assert property (
    irq_pending |-> (q_r.flag & q_r.en) != '0)
    else $error("request without armed source");

  a_prio_mask: assert property (
    (q_r.prio & ~PRIO_IMPL) == '0)
    else $error("unimplemented priority bit set");

  a_compat_ignore: assert property (
    !q_r.priority_levels_enable |-> irq_pending == (|compat_req))
    else $error("priority bits used in compatibility mode");

  a_periph_gate: assert property (
    (!q_r.priority_levels_enable && !q_r.low_level_global_enable) |-> (compat_req & PERIPH_MASK) == '0)
    else $error("peripheral passed without its enable");

  a_main_gate: assert property (
    (!q_r.priority_levels_enable && !q_r.high_level_global_enable) |-> compat_req == '0)
    else $error("source passed with main enable clear");

  a_high_permit: assert property (
    (q_r.priority_levels_enable && high_req != '0) |-> irq_pending)
    else $error("high source not permitted");

  a_low_level: assert property (
    (q_r.priority_levels_enable && !q_r.high_level_global_enable) |-> low_req == '0)
    else $error("low source passed with high enable clear");

  a_low_gate: assert property (
    (q_r.priority_levels_enable && !q_r.low_level_global_enable) |-> !any_low)
    else $error("low source passed with low enable clear");

  a_low_clears: assert property (
    ($rose(vec_load) && vec_addr == VEC_LOW) |-> !q_r.low_level_global_enable && q_r.in_low)
    else $error("low enable not cleared on take");

  a_no_low_any: assert property (
    (q_r.priority_levels_enable && q_r.in_high) |-> !any_low)
    else $error("low taken during high routine");

  a_vec_range: assert property (
    vec_addr == VEC_HIGH || vec_addr == VEC_LOW)
    else $error("vector outside the two entries");

  a_low_vec_priority_levels_enable: assert property (
    (vec_load && vec_addr == VEC_LOW) |-> q_r.priority_levels_enable)
    else $error("low vector in compatibility mode");

  a_return_from_interrupt_instr_low: assert property (
    (core_return_from_interrupt_instr && q_r.priority_levels_enable && !q_r.in_high && q_r.in_low && !wr_en)
      |=> q_r.low_level_global_enable && !q_r.in_low)
    else $error("return did not re-enable low level");

  a_return_from_interrupt_instr_compat: assert property (
    (core_return_from_interrupt_instr && !q_r.priority_levels_enable && !wr_en && q_r.st != S_SYNC) |=> q_r.high_level_global_enable)
    else $error("return did not re-enable main level");

  a_sync_takes: assert property (
    (q_r.st == S_SYNC && any_req) |=> vec_load)
    else $error("decision cycle did not vector");

  a_sync_drop: assert property (
    (q_r.st == S_SYNC && !any_req) |=> q_r.st == S_IDLE && !vec_load)
    else $error("withdrawn request still vectored");

  a_vect_once: assert property (
    vec_load |=> !vec_load)
    else $error("vector pulse longer than one cycle");

  a_load_after_sync: assert property (
    vec_load |-> $past(q_r.st) == S_SYNC)
    else $error("vector without decision cycle");

  a_high_first: assert property (
    (q_r.st == S_SYNC && any_high) |=> vec_addr == VEC_HIGH && q_r.in_high)
    else $error("high request lost the decision");

  a_req_armed: assert property (
    (q_r.flag & q_r.en) == '0 |-> !irq_pending)
    else $error("request with no armed source");

  a_event_no_en: assert property (
    (src_event != '0 && q_r.en == '0) |=> ((q_r.flag & $past(src_event)) == $past(src_event)))
    else $error("flag depends on enable");

  c_compat_take: cover property (!q_r.priority_levels_enable ##1 $rose(vec_load));
  c_high_take:   cover property (q_r.priority_levels_enable && vec_load && vec_addr == VEC_HIGH);
  c_low_take:    cover property (vec_load && vec_addr == VEC_LOW);
  c_preempt:     cover property (q_r.in_low && vec_load && vec_addr == VEC_HIGH);
  c_return:      cover property (core_return_from_interrupt_instr && q_r.in_low);

endmodule : tlpi_ctrl

`default_nettype wire

// ### tlpi_pkg.sv
package tlpi_pkg;

  // Source count and vector address width
  localparam int unsigned SRC_N = 8;
  localparam int unsigned VEC_W = 21;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FLAG   = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_PRIO   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT = 7;
  localparam int unsigned CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT = 6;
  localparam int unsigned CTRL_PRIORITY_LEVELS_ENABLE_BIT = 5;

  // Status register fields
  localparam int unsigned STAT_INHI_BIT = 0;
  localparam int unsigned STAT_INLO_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;

  // Priority register layout: implemented bits and reset value
  localparam int unsigned   PRIO_ADT_BIT  = 1;
  localparam int unsigned   PRIO_ADC_BIT  = 0;
  localparam logic [7:0]    PRIO_IMPL     = 8'hc3;
  localparam logic [7:0]    PRIO_RESET    = 8'hc3;

  // Vectors
  localparam logic [VEC_W-1:0] VEC_HIGH = 21'h00008;
  localparam logic [VEC_W-1:0] VEC_LOW  = 21'h00018;

  // Response sequence states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SYNC = 3'b010,
    S_VECT = 3'b100
  } tlpi_state_t;

endpackage : tlpi_pkg

// ### tlpi_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module tlpi_core_model
  import tlpi_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Controller side
  input  wire logic             vec_load,
  input  wire logic [VEC_W-1:0] vec_addr,
  input  wire logic             ret_req,
  output logic [VEC_W-1:0]      core_ret_pc,
  output logic                  core_return_from_interrupt_instr
);
  // Pc holds still between vectors so the pushed value is known ahead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ret_pc <= 21'h00100;
      core_return_from_interrupt_instr <= 1'b0;
    end else begin
      if (vec_load) begin
        core_ret_pc <= vec_addr + 21'h00004;
      end
      core_return_from_interrupt_instr <= ret_req;
    end
  end
endmodule : tlpi_core_model

`default_nettype wire

// ### tlpi_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end

module tlpi_ctrl_tb
  import tlpi_pkg::*;
;
  logic             pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ret_req = 0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, q;
  logic             pready, pslverr, e, irq_pending, vec_load, stack_push, core_return_from_interrupt_instr;
  logic [SRC_N-1:0] src_event = 8'h00;
  logic [VEC_W-1:0] core_ret_pc, vec_addr, stack_push_data;
  int               err_total = 0, n_compared = 0, cyc = 0;

  always #2.5 pclk = ~pclk;

  // Source 0 is the only non-peripheral source
  tlpi_ctrl #(.PERIPH_MASK(8'hfe)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .src_event(src_event),
    .core_ret_pc(core_ret_pc), .core_return_from_interrupt_instr(core_return_from_interrupt_instr), .irq_pending(irq_pending),
    .vec_load(vec_load), .vec_addr(vec_addr), .stack_push(stack_push),
    .stack_push_data(stack_push_data));
  tlpi_core_model u_core (.pclk(pclk), .presetn(presetn), .vec_load(vec_load),
    .vec_addr(vec_addr), .ret_req(ret_req), .core_ret_pc(core_ret_pc),
    .core_return_from_interrupt_instr(core_return_from_interrupt_instr));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    `CHK("rdata", x, q)
  endtask : rd

  // Pulse sources, expect a vector n cycles later (0 means none)
  task automatic fire(input logic [7:0] m, input int n, input logic [VEC_W-1:0] v);
    logic [VEC_W-1:0] pc;
    int hit;
    hit = 0;
    pc = core_ret_pc;
    @(posedge pclk);
    src_event <= m;
    for (int i = 1; i <= 8; i++) begin
      @(posedge pclk);
      src_event <= 8'h00;
      #1;
      if (i == 1) `CHK("irq_pending", (n != 0), irq_pending)
      if (vec_load === 1'b1 && hit == 0) begin
        hit = i;
        if (n != 0) begin
          `CHK("vec_addr", v, vec_addr)
          `CHK("push", 1'b1, stack_push)
          `CHK("push_data", pc, stack_push_data)
        end
      end
    end
    `CHK("latency", n, hit)
  endtask : fire

  task automatic ret();
    @(posedge pclk);
    ret_req <= 1;
    @(posedge pclk);
    ret_req <= 0;
  endtask : ret

  task automatic t_reset();
    rd(ADDR_PRIO, 32'h000000c3);
    rd(ADDR_CTRL, 32'h0);
    rd(8'h20, 32'h0);
    `CHK("slverr", 1'b1, e)
  endtask : t_reset

  task automatic t_compat();
    apb(1, ADDR_ENABLE, 32'h3);
    apb(1, ADDR_PRIO, 32'h0);
    apb(1, ADDR_CTRL, 32'h80);
    fire(8'h01, 3, VEC_HIGH);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_FLAG, 32'h1);
    apb(1, ADDR_FLAG, 32'h0);
    ret();
    rd(ADDR_CTRL, 32'h80);
    fire(8'h02, 0, VEC_HIGH);
    rd(ADDR_FLAG, 32'h2);
    apb(1, ADDR_FLAG, 32'h0);
    apb(1, ADDR_CTRL, 32'hc0);
    fire(8'h02, 3, VEC_HIGH);
    apb(1, ADDR_FLAG, 32'h0);
    apb(1, ADDR_CTRL, 32'h40);
    fire(8'h01, 0, VEC_HIGH);
    apb(1, ADDR_FLAG, 32'h0);
    ret();
  endtask : t_compat

  task automatic t_prio();
    apb(1, ADDR_PRIO, 32'h1);
    apb(1, ADDR_CTRL, 32'h20);
    fire(8'h01, 0, VEC_HIGH);
    apb(1, ADDR_FLAG, 32'h0);
    apb(1, ADDR_CTRL, 32'ha0);
    fire(8'h02, 0, VEC_LOW);
    apb(1, ADDR_FLAG, 32'h0);
    apb(1, ADDR_CTRL, 32'he0);
    fire(8'h02, 3, VEC_LOW);
    rd(ADDR_CTRL, 32'ha0);
    fire(8'h01, 3, VEC_HIGH);
    rd(ADDR_STATUS, 32'h3);
    apb(1, ADDR_FLAG, 32'h0);
    apb(1, ADDR_CTRL, 32'he0);
    fire(8'h02, 0, VEC_LOW);
    apb(1, ADDR_FLAG, 32'h0);
  endtask : t_prio

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_compat();
    t_prio();
    complete_run();
  end
endmodule : tlpi_ctrl_tb

`default_nettype wire
